// >>> hw/program_sequencer.v
/*
  program sequencer: pc, hidden return stack, vectors, table reads, alu write-back.
  assumes an external instruction decoder gives one-cycle command strobes and
  instr_step marks each instruction cycle; program memory answers combinationally.
*/
`timescale 1ns/1ps
`include "seq_consts.vh"
module program_sequencer #(
  parameter VARIANT = 2
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // instruction cycle strobe and decoded commands
  input wire instr_step,
  input wire do_call,
  input wire do_jump,
  input wire [11:0] target_addr,
  input wire return_from_call,
  input wire return_from_interrupt,
  input wire do_skip,
  input wire pc_low_byte_wr,
  input wire [7:0] pc_low_byte_data,
  input wire read_table_current_page,
  input wire read_table_last_page,
  input wire [7:0] table_pointer,
  // alu request
  input wire alu_go,
  input wire [3:0] alu_op,
  input wire [7:0] alu_a,
  input wire [7:0] alu_b,
  input wire alu_to_acc,
  // interrupt sources and enables
  input wire ext_int_pin,
  input wire timer_overflow,
  input wire adc_done,
  input wire global_int_en,
  input wire ext_int_en,
  input wire timer_int_en,
  input wire adc_int_en,
  input wire [2:0] int_flag_clear,
  // program memory
  output reg [11:0] prog_addr,
  input wire [14:0] prog_data,
  // results
  output reg [11:0] pc,
  output reg [7:0] acc,
  output reg [7:0] mem_wr_data,
  output reg mem_wr,
  output reg [3:0] status,
  output reg [7:0] table_high_byte,
  output reg [2:0] int_flags,
  output reg int_ack,
  output reg stall,
  output reg stack_full
);
  localparam PC_WIDTH = (VARIANT == 0) ? 10 : (VARIANT == 1) ? 11 : 12;
  localparam DEPTH = (VARIANT == 0) ? 4 : 6;
  localparam PW = (VARIANT == 2) ? 15 : 14;
  localparam [11:0] PC_MASK = 12'hfff >> (12 - PC_WIDTH);
  localparam [14:0] PD_MASK = 15'h7fff >> (15 - PW);
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_BRANCH = 4'h2;
  localparam [3:0] ST_TABLE = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;

  reg [3:0] state;
  reg [11:0] stack_mem [0:`STACK_DEPTH-1];
  reg [`SP_W-1:0] stack_level_index;
  reg [11:0] table_addr;
  wire stack_we;
  reg [2:0] ext_pipe;
  reg ext_level;
  reg pending_last;
  reg [11:0] next_pc;
  reg push;
  reg pop;
  reg take_int;
  reg [11:0] vector;
  reg [1:0] int_sel;
  wire [7:0] alu_result;
  wire [3:0] alu_flags;
  wire full_now;
  wire [2:0] flags_raw;
  wire int_window;

  //////////////////////////////////////////////////////////////////////////////
  // alu
  seq_alu alu_i (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .flags_in(status),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // external interrupt pin synchroniser
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_pipe <= 3'b111;
      ext_level <= 1'b1;
    end else begin
      ext_pipe <= {ext_pipe[1:0], ext_int_pin};
      if (ext_pipe[1] == ext_pipe[2]) begin
        ext_level <= ext_pipe[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt flags and acknowledge decision
  assign full_now = (stack_level_index == DEPTH[`SP_W-1:0]);
  assign flags_raw = {adc_done, timer_overflow, ~ext_level};
  // table read or skip start holds the acknowledge off two steps, the start step and its dummy step
  assign int_window = global_int_en & ~full_now & (state == ST_RUN) & instr_step &
    ~(read_table_current_page | read_table_last_page | do_skip);

  always @* begin
    take_int = 1'b0;
    vector = `VEC_EXT;
    int_sel = 2'd0;
    // full stack holds the acknowledge back; flags stay pending
    if (int_window) begin
      if (int_flags[0] & ext_int_en) begin
        take_int = 1'b1;
        vector = `VEC_EXT;
        int_sel = 2'd0;
      end else if (int_flags[1] & timer_int_en) begin
        take_int = 1'b1;
        vector = `VEC_TMR;
        int_sel = 2'd1;
      end else if (int_flags[2] & adc_int_en) begin
        take_int = 1'b1;
        vector = `VEC_ADC;
        int_sel = 2'd2;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_flags <= 3'b000;
      int_ack <= 1'b0;
    end else begin
      int_ack <= take_int;
      // set wins over clear
      int_flags <= (int_flags & ~int_flag_clear & ~({2'b00, take_int} << int_sel)) | flags_raw;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next pc, stack control
  always @* begin
    next_pc = pc;
    push = 1'b0;
    pop = 1'b0;
    if (take_int) begin
      push = 1'b1;
      next_pc = vector;
    end else if (do_call) begin
      push = 1'b1;
      next_pc = target_addr;
    end else if (do_jump) begin
      next_pc = target_addr;
    end else if (return_from_call | return_from_interrupt) begin
      pop = 1'b1;
      next_pc = stack_mem[stack_level_index - 3'd1];
    end else if (pc_low_byte_wr) begin
      next_pc = {pc[11:8], pc_low_byte_data};
    end else begin
      next_pc = pc + 12'h001;
    end
    next_pc = next_pc & PC_MASK;
  end

  always @* begin
    table_addr = {pc[11:8], table_pointer};
    if (pending_last) begin
      table_addr = {4'hf, table_pointer} & PC_MASK;
    end
  end

  always @* begin
    prog_addr = (state == ST_TABLE) ? table_addr : pc;
  end

  //////////////////////////////////////////////////////////////////////////////
  // return stack storage, no reset
  assign stack_we = push & instr_step & (state == ST_RUN) &
    ~(read_table_current_page | read_table_last_page | do_skip);

  always @(posedge clk) begin
    if (stack_we) begin
      // pushes past entry 5 are dropped until the index wraps at 8, no guard on call
      stack_mem[stack_level_index] <= pc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state, pc and stack
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RUN;
      pc <= `VEC_RESET;
      stack_level_index <= {`SP_W{1'b0}};
      pending_last <= 1'b0;
      stall <= 1'b0;
      stack_full <= 1'b0;
      table_high_byte <= 8'h00;
      mem_wr <= 1'b0;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr <= 1'b0;
      stack_full <= full_now;
      if (instr_step) begin
        case (state)
          ST_RUN: begin
            stall <= 1'b0;
            if (read_table_current_page | read_table_last_page) begin
              state <= ST_TABLE;
              pending_last <= read_table_last_page;
              stall <= 1'b1;
            end else if (do_skip) begin
              pc <= next_pc;
              state <= ST_SKIP;
              stall <= 1'b1;
            end else begin
              pc <= next_pc;
              if (push) begin
                stack_level_index <= stack_level_index + 3'd1;
              end else if (pop) begin
                stack_level_index <= stack_level_index - 3'd1;
              end
              if (push | pop | do_jump | pc_low_byte_wr) begin
                state <= ST_BRANCH;
                stall <= 1'b1;
              end
            end
          end
          ST_BRANCH: begin
            state <= ST_RUN;
            stall <= 1'b0;
          end
          ST_SKIP: begin
            pc <= (pc + 12'h001) & PC_MASK;
            state <= ST_RUN;
            stall <= 1'b0;
          end
          ST_TABLE: begin
            mem_wr <= 1'b1;
            mem_wr_data <= prog_data[7:0];
            table_high_byte <= {1'b0, prog_data[14:8] & PD_MASK[14:8]};
            pc <= (pc + 12'h001) & PC_MASK;
            pending_last <= 1'b0;
            state <= ST_RUN;
            stall <= 1'b0;
          end
          default: state <= ST_RUN;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // alu write-back and status
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc <= 8'h00;
      status <= 4'h0;
    end else if (alu_go & instr_step) begin
      status <= alu_flags;
      if (alu_to_acc) begin
        acc <= alu_result;
      end
    end
  end
endmodule

// >>> hw/seq_consts.vh
/*
  constants for the program sequencer: vectors, widths, alu op codes, flag bits.
  assumes inclusion by the sequencer and its alu.
*/
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define PC_W 12
`define STACK_DEPTH 6
`define SP_W 3
`define PROG_W 15
`define VEC_RESET 12'h000
`define VEC_EXT 12'h004
`define VEC_TMR 12'h008
`define VEC_ADC 12'h00c
`define OP_ADD 4'h0
`define OP_ADC 4'h1
`define OP_SUB 4'h2
`define OP_SBC 4'h3
`define OP_DAA 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_XOR 4'h7
`define OP_CPL 4'h8
`define OP_RR 4'h9
`define OP_RRC 4'ha
`define OP_RL 4'hb
`define OP_RLC 4'hc
`define OP_INC 4'hd
`define OP_DEC 4'he
`define OP_PASS 4'hf
`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3
`endif

// >>> hw/seq_alu.v
/*
  8-bit alu: arithmetic, logic, rotate, inc/dec with status flags.
  assumes the caller registers the result and flags.
*/
`timescale 1ns/1ps
`include "seq_consts.vh"
module seq_alu (
  // operands
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [3:0] flags_in,
  // results
  output reg [7:0] result,
  output reg [3:0] flags_out
);
  reg [8:0] sum;
  reg [4:0] half;
  reg [8:0] adj;
  reg upd_arith;
  always @* begin
    sum = 9'h000;
    half = 5'h00;
    adj = 9'h000;
    upd_arith = 1'b0;
    result = a;
    flags_out = flags_in;
    case (op)
      `OP_ADD, `OP_ADC: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == `OP_ADC) & flags_in[`FLAG_C]};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == `OP_ADC) & flags_in[`FLAG_C]};
        result = sum[7:0];
        flags_out[`FLAG_C] = sum[8];
        flags_out[`FLAG_AC] = half[4];
        flags_out[`FLAG_OV] = (a[7] == b[7]) & (sum[7] != a[7]);
      end
      `OP_SUB, `OP_SBC: begin
        // carry set means no borrow
        sum = {1'b0, a} + {1'b0, ~b} + {8'h00, (op == `OP_SUB) | flags_in[`FLAG_C]};
        half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, (op == `OP_SUB) | flags_in[`FLAG_C]};
        result = sum[7:0];
        flags_out[`FLAG_C] = sum[8];
        flags_out[`FLAG_AC] = half[4];
        flags_out[`FLAG_OV] = (a[7] != b[7]) & (sum[7] != a[7]);
      end
      `OP_DAA: begin
        adj = {1'b0, a};
        if (flags_in[`FLAG_AC] | (a[3:0] > 4'h9)) begin
          adj = adj + 9'h006;
        end
        if (flags_in[`FLAG_C] | (adj[8:4] > 5'h09)) begin
          adj = adj + 9'h060;
        end
        result = adj[7:0];
        flags_out[`FLAG_C] = flags_in[`FLAG_C] | adj[8];
      end
      `OP_AND: result = a & b;
      `OP_OR: result = a | b;
      `OP_XOR: result = a ^ b;
      `OP_CPL: result = ~a;
      `OP_RR: result = {a[0], a[7:1]};
      `OP_RL: result = {a[6:0], a[7]};
      `OP_RRC: begin
        result = {flags_in[`FLAG_C], a[7:1]};
        flags_out[`FLAG_C] = a[0];
      end
      `OP_RLC: begin
        result = {a[6:0], flags_in[`FLAG_C]};
        flags_out[`FLAG_C] = a[7];
      end
      `OP_INC: result = a + 8'h01;
      `OP_DEC: result = a - 8'h01;
      default: result = a;
    endcase
    upd_arith = (op != `OP_RR) & (op != `OP_RL) & (op != `OP_RRC) & (op != `OP_RLC) & (op != `OP_PASS);
    if (upd_arith) begin
      flags_out[`FLAG_Z] = (result == 8'h00);
    end
  end
endmodule

// >>> tb/prog_mem_model.sv
/*
  program memory model: every word is a fixed function of its address.
  assumes a 12-bit fetch address and 15-bit words, answered combinationally.
*/
`timescale 1ns/1ps
module prog_mem_model (
  // fetch port
  input wire logic [11:0] prog_addr,
  output wire logic [14:0] prog_data
);
  // high bits from address bits 11 to 5, low byte mixes page and offset
  assign prog_data = {prog_addr[11:5], prog_addr[7:0] ^ prog_addr[11:4]};
endmodule

// >>> tb/program_sequencer_sva.sv
/*
  checker for the program sequencer: pc loads, dummy cycles, table data, vectors.
  assumes commands sampled on clk with instr_step high, nrst async active low.
*/
`timescale 1ns/1ps
module program_sequencer_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // commands
  input wire logic instr_step,
  input wire logic do_call,
  input wire logic do_jump,
  input wire logic [11:0] target_addr,
  input wire logic return_from_call,
  input wire logic return_from_interrupt,
  input wire logic pc_low_byte_wr,
  input wire logic [7:0] pc_low_byte_data,
  input wire logic read_table_current_page,
  input wire logic read_table_last_page,
  input wire logic global_int_en,
  // memory and results
  input wire logic [14:0] prog_data,
  input wire logic [11:0] pc,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wr_data,
  input wire logic [7:0] table_high_byte,
  input wire logic int_ack,
  input wire logic stall,
  input wire logic stack_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a step that is taken with no interrupt able to win
  wire take = instr_step && !stall && !global_int_en;
  ////////////////////////////////////////////////////////////////////////////
  AST_PC_AT_RESET: assert property ($rose(nrst) |-> pc == 12'h000) else $error("pc not zero after reset");
  AST_CALL_LOADS: assert property (take && do_call |=> pc == $past(target_addr) && stall)
    else $error("call did not load target");
  AST_JUMP_LOADS: assert property (take && do_jump && !do_call |=> pc == $past(target_addr) && stall)
    else $error("jump did not load target");
  AST_STALL_ONE: assert property (stall && instr_step |=> !stall) else $error("dummy cycle too long");
  AST_PAGE_JUMP: assert property (take && pc_low_byte_wr && !do_call && !do_jump && !return_from_call
    && !return_from_interrupt |=> pc == {$past(pc[11:8]), $past(pc_low_byte_data)}) else $error("page jump wrong");
  AST_TABLE_DUMMY: assert property (take && (read_table_current_page || read_table_last_page) |=> stall)
    else $error("table read without dummy cycle");
  AST_TABLE_DATA: assert property (mem_wr |-> mem_wr_data == $past(prog_data[7:0])
    && table_high_byte == {1'b0, $past(prog_data[14:8])}) else $error("table word split wrong");
  AST_TABLE_HIGH_BYTE_SOURCE: assert property ($changed(table_high_byte) |-> mem_wr) else $error("high byte changed");
  AST_FULL_NO_ACK: assert property (stack_full && $past(stack_full) && $past(stack_full, 2) |-> !int_ack)
    else $error("acknowledge while stack full");
  AST_VECTOR: assert property ($rose(int_ack) |-> pc == 12'h004 || pc == 12'h008 || pc == 12'h00c)
    else $error("acknowledge without vector");
endmodule
////////////////////////////////////////////////////////////////////////////
bind program_sequencer program_sequencer_sva program_sequencer_sva_inst (.clk, .nrst, .instr_step, .do_call,
  .do_jump, .target_addr, .return_from_call, .return_from_interrupt, .pc_low_byte_wr, .pc_low_byte_data,
  .read_table_current_page, .read_table_last_page, .global_int_en, .prog_data, .pc, .mem_wr, .mem_wr_data,
  .table_high_byte, .int_ack, .stall, .stack_full);

// >>> tb/program_sequencer_test.sv
/*
  testbench for program_sequencer: alu rows, return stack, vectors, table reads.
  assumes prog_mem_model on the fetch port and instr_step held high except for the one-step hold check.
*/
`timescale 1ns/1ps
`include "seq_consts.vh"
module program_sequencer_test;
  logic clk, nrst, instr_step, do_call, do_jump, return_from_call, return_from_interrupt, do_skip;
  logic pc_low_byte_wr, read_table_current_page, read_table_last_page, alu_go, alu_to_acc, ext_int_pin;
  logic timer_overflow, adc_done, global_int_en, ext_int_en, timer_int_en, adc_int_en;
  logic mem_wr, int_ack, stall, stack_full;
  logic [2:0] int_flag_clear, int_flags;
  logic [3:0] alu_op, status;
  logic [7:0] pc_low_byte_data, table_pointer, alu_a, alu_b, acc, mem_wr_data, table_high_byte;
  logic [11:0] target_addr, prog_addr, pc;
  logic [14:0] prog_data;
  logic [11:0] saved[$];
  logic [11:0] vecs[3] = '{`VEC_EXT, `VEC_TMR, `VEC_ADC};
  int n_mismatch = 0;
  int comparisons = 0;
  typedef struct {logic [3:0] op; logic [7:0] a; logic [7:0] b; logic [7:0] r;} row_t;
  row_t rows[15] = '{'{`OP_ADD, 8'h12, 8'h34, 8'h46}, '{`OP_ADC, 8'h12, 8'h34, 8'h46},
    '{`OP_DAA, 8'h12, 8'h00, 8'h12}, '{`OP_RRC, 8'h46, 8'h00, 8'h23}, '{`OP_SBC, 8'h50, 8'h20, 8'h2f},
    '{`OP_RLC, 8'h46, 8'h00, 8'h8d},
    '{`OP_RR, 8'h03, 8'h00, 8'h81}, '{`OP_RL, 8'h81, 8'h00, 8'h03}, '{`OP_SUB, 8'h34, 8'h12, 8'h22},
    '{`OP_AND, 8'hf0, 8'h3c, 8'h30}, '{`OP_OR, 8'hf0, 8'h0c, 8'hfc}, '{`OP_XOR, 8'hff, 8'h0f, 8'hf0},
    '{`OP_CPL, 8'h0f, 8'h00, 8'hf0}, '{`OP_INC, 8'hff, 8'h00, 8'h00}, '{`OP_DEC, 8'h00, 8'h00, 8'hff}};

  program_sequencer program_sequencer_inst (.clk, .nrst, .instr_step, .do_call, .do_jump, .target_addr,
    .return_from_call, .return_from_interrupt, .do_skip, .pc_low_byte_wr, .pc_low_byte_data,
    .read_table_current_page, .read_table_last_page, .table_pointer, .alu_go, .alu_op, .alu_a, .alu_b,
    .alu_to_acc, .ext_int_pin, .timer_overflow, .adc_done, .global_int_en, .ext_int_en, .timer_int_en,
    .adc_int_en, .int_flag_clear, .prog_addr, .prog_data, .pc, .acc, .mem_wr_data, .mem_wr, .status,
    .table_high_byte, .int_flags, .int_ack, .stall, .stack_full);
  prog_mem_model prog_mem_model_inst (.prog_addr, .prog_data);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task wt;
    @(posedge clk);
    #1;
  endtask

  task clr;
    {do_call, do_jump, return_from_call, return_from_interrupt, pc_low_byte_wr, read_table_current_page,
      read_table_last_page, do_skip} = '0;
  endtask

  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task done(input string nm);
    $display("test %s ended", nm);
  endtask

  // command set by caller is taken at the next edge, then a dummy cycle
  task run(input logic [11:0] e);
    wt;
    clr;
    chk("pc", e, pc);
    chk("stall", 12'h1, {11'h0, stall});
    wt;
  endtask

  task vec(input logic [11:0] e);
    for (int k = 0; k < 10 && pc !== e; k++) wt;
    chk("vector", e, pc);
    chk("ack", 12'h1, {11'h0, int_ack});
  endtask

  task tbl(input logic [11:0] a);
    logic [14:0] w;
    w = {a[11:5], a[7:0] ^ a[11:4]};
    wt;
    clr;
    chk("stall", 12'h1, {11'h0, stall});
    wt;
    chk("written", 12'h1, {11'h0, mem_wr});
    chk("low", {4'h0, w[7:0]}, {4'h0, mem_wr_data});
    chk("high", {5'h0, w[14:8]}, {4'h0, table_high_byte});
  endtask

  task rst;
    nrst = 0;
    repeat (4) wt;
    nrst = 1;
    chk("pc", `VEC_RESET, pc);
    chk("full", 12'h0, {11'h0, stack_full});
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {do_skip, alu_go, ext_int_pin, timer_overflow, adc_done, global_int_en, ext_int_en, timer_int_en} = '0;
    {adc_int_en, int_flag_clear, alu_op, pc_low_byte_data, table_pointer, alu_a, alu_b, target_addr} = '0;
    {instr_step, alu_to_acc, ext_int_pin} = 3'h7;
    clr;
    rst;
    done("reset");
    alu_go = 1;
    foreach (rows[i]) begin
      {alu_op, alu_a, alu_b} = {rows[i].op, rows[i].a, rows[i].b};
      wt;
      chk("acc", {4'h0, rows[i].r}, {4'h0, acc});
    end
    {alu_op, alu_a, alu_b, alu_to_acc} = {`OP_ADD, 8'hff, 8'h01, 1'b0};
    wt;
    alu_go = 0;
    chk("kept", 12'h0ff, {4'h0, acc});
    chk("carry", 12'h1, {11'h0, status[`FLAG_C]});
    chk("zero", 12'h1, {11'h0, status[`FLAG_Z]});
    instr_step = 0;
    target_addr = pc;
    wt;
    chk("hold", target_addr, pc);
    instr_step = 1;
    do_skip = 1;
    target_addr = pc + 12'h002;
    run(target_addr - 12'h001);
    chk("skip", target_addr, pc);
    done("alu");
    do_jump = 1;
    target_addr = 12'h300;
    run(12'h300);
    for (int i = 1; i < 7; i++) begin
      saved.push_back(pc);
      do_call = 1;
      target_addr = {i[3:0], 8'h40};
      run(target_addr);
    end
    chk("full", 12'h1, {11'h0, stack_full});
    {global_int_en, timer_int_en, timer_overflow} = 3'h7;
    wt;
    timer_overflow = 0;
    repeat (3) wt;
    chk("flag", 12'h1, {11'h0, int_flags[1]});
    return_from_call = 1;
    run(saved.pop_back());
    vec(`VEC_TMR);
    {global_int_en, timer_int_en} = 2'h0;
    wt;
    return_from_interrupt = 1;
    run(12'h540);
    return_from_call = 1;
    run(saved.pop_back());
    done("stack");
    for (int i = 0; i < 3; i++) begin
      {global_int_en, ext_int_en, timer_int_en, adc_int_en} = 4'hf;
      {ext_int_pin, timer_overflow, adc_done} = {i != 0, i == 1, i == 2};
      wt;
      {timer_overflow, adc_done} = 2'h0;
      vec(vecs[i]);
      {ext_int_pin, global_int_en} = 2'h2;
      repeat (4) wt;
      int_flag_clear = 3'h7;
      wt;
      int_flag_clear = 3'h0;
      return_from_interrupt = 1;
      wt;
      clr;
      wt;
    end
    done("vectors");
    do_jump = 1;
    target_addr = 12'h355;
    run(12'h355);
    table_pointer = 8'h06;
    read_table_current_page = 1;
    tbl(12'h306);
    read_table_last_page = 1;
    tbl(12'hf06);
    pc_low_byte_data = 8'hab;
    pc_low_byte_wr = 1;
    run(12'h3ab);
    done("table");
    for (int i = 10; i < 13; i++) begin
      do_call = 1;
      target_addr = {4'h7, i[3:0], 4'h0};
      run(target_addr);
    end
    done("overflow");
    rst;
    for (int i = 1; i < 7; i++) begin
      do_call = 1;
      target_addr = {i[3:0], 8'h80};
      run(target_addr);
    end
    chk("full", 12'h1, {11'h0, stack_full});
    done("second reset");
    stop_test;
  end

  // whole run is about a hundred cycles; allow over twenty times that
  initial begin
    #10000;
    n_mismatch++;
    stop_test;
  end
endmodule
